// ==== hw/apm_avg.sv ====
// averager: sums sixteen samples (or passes one) and reports the mean
`timescale 1ns/1ps
module apm_avg (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        avg_off,
	input  wire logic        in_valid,
	input  wire logic [10:0] in_value,
	output logic             out_valid,
	output logic [10:0]      out_value
);
	logic [14:0] acc;
	logic [4:0]  cnt;
	wire  [4:0]  target   = avg_off ? apm_pkg::AVG_ONE : apm_pkg::AVG_COUNT;
	wire  [14:0] in_ext   = {{4{in_value[10]}}, in_value};
	wire  [14:0] next_acc = acc + in_ext;
	wire  [4:0]  next_cnt = cnt + 5'h01;
	// a target lowered mid-count ends the current result instead of wrapping the count
	wire         done     = in_valid && (next_cnt >= target);
	// signed shift keeps negative temperatures averaging correctly
	wire  [10:0] mean     = avg_off ? next_acc[10:0] : next_acc[14:4];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc       <= 15'h0000;
			cnt       <= 5'h00;
			out_valid <= 1'b0;
			out_value <= 11'h000;
		end else begin
			out_valid <= done;
			if (done) begin
				acc       <= 15'h0000;
				cnt       <= 5'h00;
				out_value <= mean;
			end else if (in_valid) begin
				acc <= next_acc;
				cnt <= next_cnt;
			end
		end
	end
endmodule

// ==== hw/apm_core.sv ====
// analog pin mode, diode sequencing, limit flags and temperature format block
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
//
// Contract
// R1: shared pins default to thermistor inputs
// R2: cfg three bits 7,6 thermistor/voltage select
// R3: cfg two bit 7 makes second diode
// R4: status two bits 2,3 diode faults
// R5: status two bits 4,5 thermistor faults
// R6: software masks faults of unused mode
// R7: thermistor mode: mask diode faults 0x13
// R8: second diode: mask thermistor, voltage two
// R9: first shared channel excursion sets bit 6
// R10: second shared channel excursion sets bit 5
// R11: software turns fan control off first
// R12: diode bias cycles base, mid, high
// R13: results average sixteen measurement cycles
// R14: main byte plus two fraction bits
// R15: binary range code equals degrees
// R16: offset binary adds sixty-four
// R17: cfg one bit 7 selects range
// R18: software changes range once, waits
// R19: single channel select field 000/001/010
// R20: each channel compares low, high limits
// R21: binary below zero reads zero
// R22: binary above 127 saturates
// R23: voltage codes saturate
module apm_core (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata,
	// front end: raw converter result, asynchronous to this clock
	input  wire logic [10:0] adc_value,
	input  wire logic        adc_fault,
	input  wire logic        adc_ready,
	// front end steering
	output logic [2:0]       adc_chan,
	output logic [1:0]       diode_bias,
	output logic             pin_one_thermistor,
	output logic             pin_two_thermistor,
	output logic             pins_second_diode,
	output logic             alert_n
);
	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] cfg_one;
	logic [7:0] cfg_two;
	logic [7:0] cfg_three;
	logic [7:0] cfg_four;
	logic [7:0] mask_one;
	logic [7:0] mask_two;
	logic [7:0] stat_one;
	logic [7:0] stat_two;
	logic [7:0] lim_lo [0:4];
	logic [7:0] lim_hi [0:4];
	logic [7:0] val_main [0:4];
	logic [1:0] val_frac [0:4];

	apm_pkg::apm_bus_s bus;
	assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_one   <= 8'h00;
			cfg_two   <= 8'h00;
			cfg_three <= apm_pkg::CFG_THREE_RST; // [R1]
			cfg_four  <= 8'h00;
			mask_one  <= 8'h00;
			mask_two  <= 8'h00;
		end else if (bus.wr) begin
			if (bus.addr == apm_pkg::REG_CFG_ONE) begin
				cfg_one <= bus.wdata; // [R17]
			end else if (bus.addr == apm_pkg::REG_CFG_TWO) begin
				cfg_two <= bus.wdata; // [R3]
			end else if (bus.addr == apm_pkg::REG_CFG_THREE) begin
				cfg_three <= bus.wdata; // [R2]
			end else if (bus.addr == apm_pkg::REG_CFG_FOUR) begin
				cfg_four <= bus.wdata;
			end else if (bus.addr == apm_pkg::REG_MASK_ONE) begin
				mask_one <= bus.wdata;
			end else if (bus.addr == apm_pkg::REG_MASK_TWO) begin
				mask_two <= bus.wdata;
			end
		end
	end

	wire second_dio = cfg_two[apm_pkg::BIT_SECOND_DIO];
	wire avg_off    = cfg_two[apm_pkg::BIT_AVG_OFF];
	wire th_one     = cfg_three[apm_pkg::BIT_TH_ONE] && !second_dio;
	wire th_two     = cfg_three[apm_pkg::BIT_TH_TWO] && !second_dio;
	wire range_ext  = cfg_one[apm_pkg::BIT_RANGE_EXT];
	wire single     = cfg_four[apm_pkg::BIT_SINGLE];

	// limit registers: index 0 first shared, 1 second, 2 supply, 3 remote, 4 local
	wire [7:0] lim_lo_addr [0:4];
	wire [7:0] lim_hi_addr [0:4];
	assign lim_lo_addr = '{apm_pkg::REG_LIM_LO_ONE, apm_pkg::REG_LIM_LO_TWO,
		apm_pkg::REG_LIM_LO_SUP, apm_pkg::REG_LIM_LO_REM, apm_pkg::REG_LIM_LO_LOC};
	assign lim_hi_addr = '{apm_pkg::REG_LIM_HI_ONE, apm_pkg::REG_LIM_HI_TWO,
		apm_pkg::REG_LIM_HI_SUP, apm_pkg::REG_LIM_HI_REM, apm_pkg::REG_LIM_HI_LOC};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_lim
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					lim_lo[gi] <= apm_pkg::LIM_LO_RST;
					lim_hi[gi] <= (gi >= int'(apm_pkg::APM_CH_REMOTE)) ?
					              apm_pkg::LIM_HI_T_RST : apm_pkg::LIM_HI_RST;
				end else if (bus.wr && bus.addr == lim_lo_addr[gi]) begin
					lim_lo[gi] <= bus.wdata;
				end else if (bus.wr && bus.addr == lim_hi_addr[gi]) begin
					lim_hi[gi] <= bus.wdata;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// input synchroniser
	// ------------------------------------------------------------
	// the value bus is qualified by ready; ready is synchronised, and the value is
	// captured only from the second stage so both stages see a settled word
	logic [12:0] sync_a;
	logic [12:0] sync_b;
	logic        ready_last;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_a     <= 13'h0000;
			sync_b     <= 13'h0000;
			ready_last <= 1'b0;
		end else begin
			sync_a     <= {adc_ready, adc_fault, adc_value};
			sync_b     <= sync_a;
			ready_last <= sync_b[12];
		end
	end

	apm_pkg::apm_sample_s smp;
	assign smp = '{valid: sync_b[12] && !ready_last, value: sync_b[10:0], fault: sync_b[11]};

	// ------------------------------------------------------------
	// measurement sequencer
	// ------------------------------------------------------------
	logic [15:0] step_cnt;
	logic [2:0]  chan;
	logic [1:0]  bias;
	wire         step_tick = (step_cnt == 16'(apm_pkg::STEP_CYCLES - 1));
	wire         is_diode  = (chan == apm_pkg::APM_CH_REMOTE) ||
	                         (chan == apm_pkg::APM_CH_LOCAL) ||
	                         (second_dio && chan == apm_pkg::APM_CH_AIN_ONE);
	// a diode result counts only samples from the high bias step, whichever steps came before it
	wire         bias_last = !is_diode || (bias == apm_pkg::APM_BIAS_HIGH);
	wire [1:0]   next_bias = bias_last ? apm_pkg::APM_BIAS_BASE : bias + 2'b01; // [R12]
	wire         res_done;
	wire [2:0]   next_chan = single ? {1'b0, cfg_four[1:0]} :               // [R19]
	                         (chan == apm_pkg::APM_CH_LOCAL) ? apm_pkg::APM_CH_AIN_ONE :
	                         (second_dio && chan == apm_pkg::APM_CH_AIN_ONE) ?
	                         apm_pkg::APM_CH_SUPPLY : chan + 3'b001;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			step_cnt <= 16'h0000;
			bias     <= apm_pkg::APM_BIAS_BASE;
			chan     <= apm_pkg::APM_CH_AIN_ONE;
		end else begin
			step_cnt <= step_tick ? 16'h0000 : step_cnt + 16'h0001;
			if (step_tick) begin
				bias <= next_bias;
			end
			if (res_done) begin
				chan <= next_chan;
			end
		end
	end

	// ------------------------------------------------------------
	// averaging
	// ------------------------------------------------------------
	wire        avg_valid;
	wire [10:0] avg_value;
	apm_avg u_avg (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.avg_off   (avg_off),
		.in_valid  (smp.valid && bias_last), // [R13]
		.in_value  (smp.value),
		.out_valid (avg_valid),
		.out_value (avg_value)
	);
	assign res_done = avg_valid;

	// ------------------------------------------------------------
	// result formatting
	// ------------------------------------------------------------
	wire        is_temp  = is_diode || (chan == apm_pkg::APM_CH_AIN_ONE && th_one) ||
	                       (chan == apm_pkg::APM_CH_AIN_TWO && th_two);
	// temperature is signed quarter degrees; voltage is an unsigned 10-bit code
	wire signed [10:0] t_q  = avg_value;
	wire signed [11:0] t_off = 12'(t_q) + 12'($signed({2'b00, apm_pkg::OFFSET_QTR}));
	wire [9:0]  bin_q   = (t_q <= $signed(apm_pkg::ZERO_QTR)) ? 10'h000 :            // [R21]
	                      (t_q > $signed({1'b0, apm_pkg::BIN_MAX_QTR})) ?
	                      apm_pkg::BIN_MAX_QTR : t_q[9:0];                            // [R22] [R15]
	wire [9:0]  off_q   = t_off[11] ? 10'h000 : (t_off[10] ? 10'h3ff : t_off[9:0]);  // [R16]
	wire [9:0]  temp_q  = range_ext ? off_q : bin_q;                                 // [R17]
	wire [9:0]  volt_c  = avg_value[10] ? 10'h3ff : avg_value[9:0];                  // [R23]
	wire [9:0]  code    = is_temp ? temp_q : volt_c;
	wire [2:0]  slot    = (chan > apm_pkg::APM_CH_LOCAL) ? apm_pkg::APM_CH_LOCAL : chan;

	generate
		for (gi = 0; gi < 5; gi++) begin : g_val
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					val_main[gi] <= 8'h00;
					val_frac[gi] <= 2'b00;
				end else if (res_done && slot == 3'(gi)) begin
					val_main[gi] <= code[9:2]; // [R14]
					val_frac[gi] <= code[1:0];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// limit and fault flags
	// ------------------------------------------------------------
	wire       excursion = (code[9:2] < lim_lo[slot]) || (code[9:2] > lim_hi[slot]); // [R20]
	wire [7:0] ool_bits  = {1'b0, slot == 3'd0, slot == 3'd1, slot == 3'd2,
	                        slot == 3'd3, slot == 3'd4, 2'b00};
	wire [7:0] set_one   = (res_done && excursion) ? ool_bits : 8'h00; // [R9] [R10]
	wire       fault_now = res_done && smp.fault;
	wire [7:0] set_two   = {2'b00,
		fault_now && chan == apm_pkg::APM_CH_AIN_TWO && th_two,                  // [R5]
		fault_now && chan == apm_pkg::APM_CH_AIN_ONE && th_one,
		fault_now && chan == apm_pkg::APM_CH_AIN_ONE && second_dio,              // [R4]
		fault_now && chan == apm_pkg::APM_CH_REMOTE,
		2'b00};
	wire rd_one = bus.rd && bus.addr == apm_pkg::REG_STATUS_ONE;
	wire rd_two = bus.rd && bus.addr == apm_pkg::REG_STATUS_TWO;
	// clear on read; a flag set in the same cycle survives the read
	wire [7:0] next_stat_one = (rd_one ? 8'h00 : stat_one) | set_one;
	wire [7:0] next_stat_two = (rd_two ? 8'h00 : stat_two) | set_two;
	wire       alert_any = |(stat_one & ~mask_one) || |(stat_two & ~mask_two);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_one <= 8'h00;
			stat_two <= 8'h00;
			alert_n  <= 1'b1;
		end else begin
			stat_one <= next_stat_one;
			stat_two <= next_stat_two;
			alert_n  <= !alert_any;
		end
	end

	// ------------------------------------------------------------
	// read mux and steering outputs
	// ------------------------------------------------------------
	wire [7:0] next_rdata =
		(bus.addr == apm_pkg::REG_CFG_ONE)     ? cfg_one :
		(bus.addr == apm_pkg::REG_CFG_TWO)     ? cfg_two :
		(bus.addr == apm_pkg::REG_CFG_THREE)   ? cfg_three :
		(bus.addr == apm_pkg::REG_CFG_FOUR)    ? cfg_four :
		(bus.addr == apm_pkg::REG_EXT_ONE)     ? {6'h00, val_frac[3]} :
		(bus.addr == apm_pkg::REG_EXT_TWO)     ? {6'h00, val_frac[4]} :
		(bus.addr == apm_pkg::REG_AIN_ONE_VAL) ? val_main[0] :
		(bus.addr == apm_pkg::REG_AIN_TWO_VAL) ? val_main[1] :
		(bus.addr == apm_pkg::REG_SUPPLY_VAL)  ? val_main[2] :
		(bus.addr == apm_pkg::REG_REMOTE_VAL)  ? val_main[3] :
		(bus.addr == apm_pkg::REG_LOCAL_VAL)   ? val_main[4] :
		(bus.addr == apm_pkg::REG_STATUS_ONE)  ? stat_one :
		(bus.addr == apm_pkg::REG_STATUS_TWO)  ? stat_two :
		(bus.addr == apm_pkg::REG_MASK_ONE)    ? mask_one :
		(bus.addr == apm_pkg::REG_MASK_TWO)    ? mask_two :
		(bus.addr >= apm_pkg::REG_LIM_LO_ONE && bus.addr <= apm_pkg::REG_LIM_HI_LOC) ?
		(bus.addr[0] ? lim_hi[3'((bus.addr - apm_pkg::REG_LIM_LO_ONE) >> 1)] :
		               lim_lo[3'((bus.addr - apm_pkg::REG_LIM_LO_ONE) >> 1)]) :
		8'h00;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata          <= 8'h00;
			adc_chan           <= apm_pkg::APM_CH_AIN_ONE;
			diode_bias         <= apm_pkg::APM_BIAS_BASE;
			pin_one_thermistor <= 1'b1;
			pin_two_thermistor <= 1'b1;
			pins_second_diode  <= 1'b0;
		end else begin
			reg_rdata          <= bus.rd ? next_rdata : 8'h00;
			adc_chan           <= chan;
			diode_bias         <= bias; // [R12]
			pin_one_thermistor <= th_one; // [R2]
			pin_two_thermistor <= th_two;
			pins_second_diode  <= second_dio; // [R3]
		end
	end
endmodule

// ==== hw/apm_pkg.sv ====
// package: register map, field positions and types for the analog pin mode block
package apm_pkg;
	// register offsets
	localparam logic [7:0] REG_CFG_ONE      = 8'h00;
	localparam logic [7:0] REG_CFG_TWO      = 8'h01;
	localparam logic [7:0] REG_CFG_THREE    = 8'h02;
	localparam logic [7:0] REG_CFG_FOUR     = 8'h03;
	localparam logic [7:0] REG_AFC_CFG      = 8'h05;
	localparam logic [7:0] REG_EXT_ONE      = 8'h08;
	localparam logic [7:0] REG_EXT_TWO      = 8'h09;
	localparam logic [7:0] REG_AIN_ONE_VAL  = 8'h0a;
	localparam logic [7:0] REG_AIN_TWO_VAL  = 8'h0b;
	localparam logic [7:0] REG_SUPPLY_VAL   = 8'h0c;
	localparam logic [7:0] REG_REMOTE_VAL   = 8'h0d;
	localparam logic [7:0] REG_LOCAL_VAL    = 8'h0e;
	localparam logic [7:0] REG_STATUS_ONE   = 8'h10;
	localparam logic [7:0] REG_STATUS_TWO   = 8'h11;
	localparam logic [7:0] REG_MASK_ONE     = 8'h12;
	localparam logic [7:0] REG_MASK_TWO     = 8'h13;
	localparam logic [7:0] REG_LIM_LO_ONE   = 8'h14;
	localparam logic [7:0] REG_LIM_HI_ONE   = 8'h15;
	localparam logic [7:0] REG_LIM_LO_TWO   = 8'h16;
	localparam logic [7:0] REG_LIM_HI_TWO   = 8'h17;
	localparam logic [7:0] REG_LIM_LO_SUP   = 8'h18;
	localparam logic [7:0] REG_LIM_HI_SUP   = 8'h19;
	localparam logic [7:0] REG_LIM_LO_REM   = 8'h1a;
	localparam logic [7:0] REG_LIM_HI_REM   = 8'h1b;
	localparam logic [7:0] REG_LIM_LO_LOC   = 8'h1c;
	localparam logic [7:0] REG_LIM_HI_LOC   = 8'h1d;

	// field positions
	localparam int BIT_RANGE_EXT   = 7;  // cfg one
	localparam int BIT_SECOND_DIO  = 7;  // cfg two
	localparam int BIT_AVG_OFF     = 4;  // cfg two
	localparam int BIT_TH_ONE      = 7;  // cfg three
	localparam int BIT_TH_TWO      = 6;  // cfg three
	localparam int BIT_SINGLE      = 3;  // cfg four
	localparam int BIT_OOL_ONE     = 6;  // status one
	localparam int BIT_OOL_TWO     = 5;
	localparam int BIT_OOL_SUP     = 4;
	localparam int BIT_OOL_REM     = 3;
	localparam int BIT_OOL_LOC     = 2;
	localparam int BIT_DIO_ONE_NC  = 2;  // status two
	localparam int BIT_DIO_TWO_NC  = 3;
	localparam int BIT_TH_ONE_NC   = 4;
	localparam int BIT_TH_TWO_NC   = 5;

	// reset values
	localparam logic [7:0] CFG_THREE_RST = 8'hc0;
	localparam logic [7:0] LIM_LO_RST    = 8'h00;
	localparam logic [7:0] LIM_HI_RST    = 8'hff;
	localparam logic [7:0] LIM_HI_T_RST  = 8'h7f;

	// format constants
	localparam logic [9:0]  OFFSET_QTR   = 10'h100; // +64 degrees in quarter steps
	localparam logic [9:0]  BIN_MAX_QTR  = 10'h1ff; // 127.75 degrees
	localparam logic [10:0] ZERO_QTR     = 11'h000;
	localparam logic [4:0]  AVG_COUNT    = 5'h10;   // sixteen cycles per result
	localparam logic [4:0]  AVG_ONE      = 5'h01;

	// timing: one raw measurement step
	localparam int CLK_HZ       = 40000000;
	localparam int STEP_US      = 1000;
	localparam int STEP_CYCLES  = CLK_HZ / 1000000 * STEP_US;

	// channel selection
	typedef enum logic [2:0] {
		APM_CH_AIN_ONE = 3'b000,
		APM_CH_AIN_TWO = 3'b001,
		APM_CH_SUPPLY  = 3'b010,
		APM_CH_REMOTE  = 3'b011,
		APM_CH_LOCAL   = 3'b100
	} apm_chan_e;

	// diode bias phase
	typedef enum logic [1:0] {
		APM_BIAS_BASE = 2'b00,
		APM_BIAS_MID  = 2'b01,
		APM_BIAS_HIGH = 2'b10
	} apm_bias_e;

	// one raw sample from the front end
	typedef struct packed {
		logic        valid;
		logic [10:0] value;   // voltage code, or signed quarter-degree temperature
		logic        fault;   // open or short seen on the input
	} apm_sample_s;

	// register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} apm_bus_s;
endpackage

// ==== testbench/apm_core_checker.sv ====
// concurrent checks on the ports of the analog pin mode core
`timescale 1ns/1ps
module apm_core_checker (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] adc_chan,
	input wire logic [1:0] diode_bias,
	input wire logic       pin_one_thermistor,
	input wire logic       pin_two_thermistor,
	input wire logic       pins_second_diode
);
	default clocking cb @(posedge sys_clk); endclocking

	sequence s_rd(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	sequence s_wr(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	a_reset_pins: assert property (disable iff (1'b0) sys_rst |=>
		pin_one_thermistor && pin_two_thermistor && !pins_second_diode)
		else $error("pins not in thermistor mode after reset");
	a_rdata_idle: assert property (disable iff (sys_rst) !$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (disable iff (sys_rst) s_rd(8'h04) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cfg3_write: assert property (disable iff (sys_rst) s_wr(apm_pkg::REG_CFG_THREE) |-> ##2
		pins_second_diode ||
		{pin_one_thermistor, pin_two_thermistor} == $past(reg_wdata[7:6], 2))
		else $error("thermistor select not taken from write");
	a_cfg3_readback: assert property (disable iff (sys_rst) s_rd(apm_pkg::REG_CFG_THREE) |=>
		pins_second_diode || reg_rdata[7:6] == {pin_one_thermistor, pin_two_thermistor})
		else $error("thermistor select readback mismatch");
	a_diode_write: assert property (disable iff (sys_rst) s_wr(apm_pkg::REG_CFG_TWO) |-> ##2
		pins_second_diode == $past(reg_wdata[7], 2))
		else $error("second diode select not taken from write");
	a_diode_readback: assert property (disable iff (sys_rst) s_rd(apm_pkg::REG_CFG_TWO) |=>
		reg_rdata[7] == pins_second_diode)
		else $error("second diode readback mismatch");
	a_bias_legal: assert property (disable iff (sys_rst) diode_bias != 2'b11)
		else $error("illegal bias step");
	a_chan_legal: assert property (disable iff (sys_rst) adc_chan <= 3'h4)
		else $error("illegal channel");
endmodule

bind apm_core apm_core_checker chk_u (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_chan(adc_chan),
	.diode_bias(diode_bias), .pin_one_thermistor(pin_one_thermistor),
	.pin_two_thermistor(pin_two_thermistor), .pins_second_diode(pins_second_diode)
);

// ==== testbench/apm_core_test.sv ====
// self-checking testbench for the analog pin mode core
`timescale 1ns/1ps
module apm_core_test;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic [10:0] adc_value;
	logic        adc_fault;
	logic        adc_ready;
	logic [2:0]  adc_chan;
	logic [1:0]  diode_bias;
	logic        pin_one_thermistor;
	logic        pin_two_thermistor;
	logic        pins_second_diode;
	logic        alert_n;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #12.5 sys_clk = ~sys_clk;

	apm_core dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.adc_value(adc_value), .adc_fault(adc_fault), .adc_ready(adc_ready),
		.adc_chan(adc_chan), .diode_bias(diode_bias), .pin_one_thermistor(pin_one_thermistor),
		.pin_two_thermistor(pin_two_thermistor), .pins_second_diode(pins_second_diode),
		.alert_n(alert_n));

	apm_front_model model_u (.adc_chan(adc_chan), .sys_clk(sys_clk), .adc_value(adc_value),
		.adc_fault(adc_fault), .adc_ready(adc_ready));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// a hang still ends in the closing report
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] d;
		rd(a, d);
		check(d & m, exp);
	endtask

	// pin outputs follow a register write two edges later
	task automatic settle();
		@(posedge sys_clk);
		#1;
	endtask

	// new input value, then wait 64 cycles, four single-sample results
	task automatic put(input int ch, input logic [10:0] v, input logic f);
		@(posedge sys_clk);
		model_u.chan_val[ch] <= v;
		model_u.chan_fault[ch] <= f;
		repeat (64) @(posedge sys_clk);
	endtask

	task automatic t_reset();
		rc(apm_pkg::REG_CFG_THREE, apm_pkg::CFG_THREE_RST, 8'hff);
		check({6'h00, pin_one_thermistor, pin_two_thermistor}, 8'h03);
		rc(8'h04, 8'h00, 8'hff);
		$display("reset test done");
	endtask

	task automatic t_modes();
		wr(apm_pkg::REG_CFG_THREE, 8'h40);
		settle();
		check({6'h00, pin_one_thermistor, pin_two_thermistor}, 8'h01);
		rc(apm_pkg::REG_CFG_THREE, 8'h40, 8'hc0);
		wr(apm_pkg::REG_CFG_TWO, 8'h90);
		settle();
		check({7'h00, pins_second_diode}, 8'h01);
		wr(apm_pkg::REG_CFG_TWO, 8'h10);
		settle();
		check({7'h00, pins_second_diode}, 8'h00);
		$display("mode test done");
	endtask

	task automatic t_voltage();
		logic [7:0] d;
		wr(apm_pkg::REG_AFC_CFG, 8'h00);
		wr(apm_pkg::REG_CFG_THREE, 8'h00);
		wr(apm_pkg::REG_CFG_FOUR, 8'h08);
		wr(apm_pkg::REG_LIM_HI_ONE, 8'h80);
		put(0, 11'h100, 1'b0);
		rc(apm_pkg::REG_AIN_ONE_VAL, 8'h40, 8'hff);
		rd(apm_pkg::REG_STATUS_ONE, d);
		put(0, 11'h7ff, 1'b0);
		rc(apm_pkg::REG_AIN_ONE_VAL, 8'hff, 8'hff);
		rc(apm_pkg::REG_STATUS_ONE, 8'h40, 8'h40);
		check({7'h00, alert_n}, 8'h00);
		wr(apm_pkg::REG_CFG_FOUR, 8'h09);
		wr(apm_pkg::REG_LIM_HI_TWO, 8'h10);
		put(1, 11'h0c0, 1'b0);
		rc(apm_pkg::REG_AIN_TWO_VAL, 8'h30, 8'hff);
		rc(apm_pkg::REG_STATUS_ONE, 8'h20, 8'h20);
		// averaging back on: wait out one mixed and one clean sixteen-sample result
		wr(apm_pkg::REG_CFG_TWO, 8'h00);
		put(1, 11'h0c4, 1'b0);
		repeat (512) @(posedge sys_clk);
		rc(apm_pkg::REG_AIN_TWO_VAL, 8'h31, 8'hff);
		wr(apm_pkg::REG_CFG_TWO, 8'h10);
		$display("voltage test done");
	endtask

	task automatic t_temp();
		int         deg [8] = '{-160, 100, 800, 511, 100, -256, 764, 0};
		logic [7:0] exp [8] = '{8'h00, 8'h19, 8'h7f, 8'h7f, 8'h59, 8'h00, 8'hff, 8'h40};
		wr(apm_pkg::REG_CFG_THREE, 8'hc0);
		wr(apm_pkg::REG_CFG_FOUR, 8'h08);
		wr(apm_pkg::REG_CFG_ONE, 8'h00);
		for (int i = 0; i < 8; i++) begin
			if (i == 4) begin
				wr(apm_pkg::REG_CFG_ONE, 8'h80);
			end
			put(0, deg[i][10:0], 1'b0);
			rc(apm_pkg::REG_AIN_ONE_VAL, exp[i], 8'hff);
		end
		$display("temperature format test done");
	endtask

	task automatic t_faults();
		logic [7:0] d;
		put(0, 11'h064, 1'b1);
		rd(apm_pkg::REG_STATUS_TWO, d);
		repeat (32) @(posedge sys_clk);
		rc(apm_pkg::REG_STATUS_TWO, 8'h10, 8'h10);
		wr(apm_pkg::REG_CFG_FOUR, 8'h09);
		put(1, 11'h064, 1'b1);
		rc(apm_pkg::REG_STATUS_TWO, 8'h20, 8'h20);
		// software masks every source, so stale flags must not hold the alert
		wr(apm_pkg::REG_MASK_ONE, 8'hff);
		wr(apm_pkg::REG_MASK_TWO, 8'hff);
		rd(apm_pkg::REG_STATUS_ONE, d);
		rd(apm_pkg::REG_STATUS_TWO, d);
		repeat (40) @(posedge sys_clk);
		check({7'h00, alert_n}, 8'h01);
		$display("fault test done");
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_modes();
		t_voltage();
		t_temp();
		t_faults();
		end_of_test();
	end
endmodule

// ==== testbench/apm_front_model.sv ====
// front end model: one converted sample of the selected channel every sixteen cycles
`timescale 1ns/1ps
module apm_front_model (
	input  wire logic [2:0] adc_chan,
	input  wire logic       sys_clk,
	output logic [10:0]     adc_value,
	output logic            adc_fault,
	output logic            adc_ready
);
	logic [10:0] chan_val [0:4];
	logic        chan_fault [0:4];
	// first latch waits until the core has left reset, so the channel index is known
	logic [3:0]  cnt = 4'h1;

	initial begin
		for (int i = 0; i < 5; i++) begin
			chan_val[i] = 11'h000;
			chan_fault[i] = 1'b0;
		end
		adc_value = 11'h000;
		adc_fault = 1'b0;
		adc_ready = 1'b0;
	end

	// value latched four cycles before ready rises so it is stable around the edge
	always @(posedge sys_clk) begin
		cnt <= cnt + 4'h1;
		if (cnt == 4'h0) begin
			adc_value <= chan_val[adc_chan];
			adc_fault <= chan_fault[adc_chan];
		end
		adc_ready <= (cnt >= 4'h4) && (cnt < 4'hc);
	end
endmodule
